// ===== core/tmc_defines.vh
// Register map, field positions, reset values and encodings of the timer modulo and channel block.
// Assumes a 32-bit APB slave with one byte-wide register in the low bits of each word, except the 16-bit count in the low half.
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

`define TMC_ADDR_STATUS_CTRL   8'h00
`define TMC_ADDR_COUNT         8'h04
`define TMC_ADDR_MOD_HIGH      8'h08
`define TMC_ADDR_MOD_LOW       8'h0C
`define TMC_ADDR_CHAN_CTRL     8'h10
`define TMC_ADDR_CHAN_VAL_HIGH 8'h14
`define TMC_ADDR_CHAN_VAL_LOW  8'h18
`define TMC_ADDR_DEBUG         8'h1C

`define TMC_MOD_RESET          16'h0000
`define TMC_FREE_PRE_TOP       16'hFFFE
`define TMC_FREE_TOP           16'hFFFF

`define TMC_SC_OVF_BIT         7
`define TMC_SC_CENTRE_BIT      5
`define TMC_SC_CLK_HI          4
`define TMC_SC_CLK_LO          3

`define TMC_CH_FLAG_BIT        7
`define TMC_CH_IE_BIT          6
`define TMC_CH_MODE_HI         5
`define TMC_CH_MODE_LO         4
`define TMC_CH_EDGE_HI         3
`define TMC_CH_EDGE_LO         2

`define TMC_CLK_OFF            2'b00
`define TMC_EDGE_NONE          2'b00
`define TMC_EDGE_RISE          2'b01
`define TMC_EDGE_FALL          2'b10
`define TMC_EDGE_BOTH          2'b11
`define TMC_MODE_CAPTURE       2'b00
`define TMC_MODE_COMPARE       2'b01

`endif

// ===== core/tmc_timer.v
// Timer with 16-bit counter, buffered modulo register and one capture/compare/PWM channel behind APB.
// Assumes the counter steps once per clock whenever a clock source is selected outside debug mode; the prescaler lies outside.
//
// Behaviour
// - Outside centre-aligned mode, at modulo the counter restarts from zero next step and sets overflow flag.
// - Overflow flag is held off between the two modulo byte writes.
// - Reset clears modulo to zero, giving a free-running counter.
// - Modulo bytes go to a buffer; with clock off, second byte loads it.
// - With clock on, load on step modulo-1 to modulo, or FFFE to FFFF.
// - Any main status/control write resets the modulo byte pairing.
// - In debug mode the byte pairing stays frozen, except status/control writes.
// - In debug mode modulo byte writes go straight into the register.
// - Capture mode sets the channel flag on the selected pin edge.
// - Compare and PWM modes set the channel flag when counter equals value.
// - PWM at 0% or 100% duty never sets the channel flag.
// - Channel interrupt requested while flag and enable are both set.
// - Flag clears by read while set then write zero; one has no effect.
// - A new event during the clear sequence restarts it; flag stays set.
// - Reset clears channel flag and interrupt enable.
// - Edge/level 00 releases the pin; the channel still works as timer.
// - Capture on rising for 01, falling for 10, either edge for 11.
// - Compare toggles for 01, clears for 10, sets for 11.
// - Edge-aligned PWM: 10 high-true clear on compare, X1 low-true set.
// - Centre-aligned PWM: 10 clears on up-count compare, X1 sets on it.
// - Centre-aligned select makes the counter count up and down.
// - Clock source 00 stops the counter.
// - A capture event stores the counter into the channel value.
`timescale 1ns/1ps
`include "tmc_defines.vh"

module tmc_timer
(
  // Clock and reset.
  input  wire        mclk,
  input  wire        rst_b,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Channel pin and interrupt.
  input  wire        chanPinIn,
  output reg         chanPinOut,
  output reg         chanPinOe,
  output reg         chanIrq
);

  reg  [1:0]  clockSourceSelect;
  reg         centreAlignedSelect;
  reg         overflowFlag;
  reg         overflowIe;
  reg         ovfArmed;
  reg         xferWrap;
  reg  [15:0] count;
  reg         countDown;
  reg  [15:0] modulo;
  reg  [7:0]  modBufHigh;
  reg  [7:0]  modBufLow;
  reg         modHighSeen;
  reg         modLowSeen;
  reg         modPending;
  reg         debugMode;
  reg         channelEventFlag;
  reg         channelIrqEnable;
  reg  [1:0]  channelMode;
  reg  [1:0]  edgeLevelSelect;
  reg         chanArmed;
  reg  [15:0] chanValue;
  reg         pinMeta;
  reg         pinSync;
  reg         pinPrev;
  reg         pinLevel;

  // Reads load on the first access edge so data stands with pready; writes land with pready.
  wire        access   = psel && penable && !pready;
  wire        done     = psel && penable && pready;
  wire        wrEn     = done && pwrite;
  wire        rdEn     = access && !pwrite;
  wire        wrSc     = wrEn && (paddr == `TMC_ADDR_STATUS_CTRL);
  wire        wrCnt    = wrEn && (paddr == `TMC_ADDR_COUNT);
  wire        wrModH   = wrEn && (paddr == `TMC_ADDR_MOD_HIGH);
  wire        wrModL   = wrEn && (paddr == `TMC_ADDR_MOD_LOW);
  wire        wrCh     = wrEn && (paddr == `TMC_ADDR_CHAN_CTRL);
  wire        wrValH   = wrEn && (paddr == `TMC_ADDR_CHAN_VAL_HIGH);
  wire        wrValL   = wrEn && (paddr == `TMC_ADDR_CHAN_VAL_LOW);
  wire        wrDbg    = wrEn && (paddr == `TMC_ADDR_DEBUG);
  wire        rdSc     = rdEn && (paddr == `TMC_ADDR_STATUS_CTRL);
  wire        rdCh     = rdEn && (paddr == `TMC_ADDR_CHAN_CTRL);

  // Debug mode freezes the counter as well as the modulo pairing.
  wire        running  = (clockSourceSelect != `TMC_CLK_OFF) && !debugMode;
  wire        freeRun  = (modulo == `TMC_MOD_RESET);
  wire [15:0] top      = freeRun ? `TMC_FREE_TOP : modulo;

  // Next counter value, covering up-counting and the up/down centre-aligned sweep.
  reg  [15:0] next_count;
  reg         next_countDown;
  always @*
  begin
    next_count     = count;
    next_countDown = countDown;
    if (centreAlignedSelect)
    begin
      if (countDown)
      begin
        next_count = count - 16'h0001;
        if (count == 16'h0001)
          next_countDown = 1'b0;
      end
      else if (count >= top)
      begin
        next_count     = count - 16'h0001;
        next_countDown = 1'b1;
      end
      else
        next_count = count + 16'h0001;
    end
    else
    begin
      next_countDown = 1'b0;
      // The step that loads a new modulo lands on the old limit, which still ends the period.
      if (count == top || xferWrap)
        next_count = 16'h0000;
      else
        next_count = count + 16'h0001;
    end
  end

  wire        wrapEvt  = running && (centreAlignedSelect ? (countDown && count == 16'h0001) : (count == top || xferWrap));
  // A pending modulo moves in on the step onto the current limit.
  wire        modXfer  = modPending && running && (next_count == top) && (count == top - 16'h0001);

  wire        edgeOn   = (edgeLevelSelect != `TMC_EDGE_NONE);
  wire        isPwm    = centreAlignedSelect || channelMode[1];
  wire        isCap    = !isPwm && (channelMode == `TMC_MODE_CAPTURE);
  wire        rise     = pinSync && !pinPrev;
  wire        fall     = !pinSync && pinPrev;
  wire        capEvt   = isCap && ((edgeLevelSelect == `TMC_EDGE_RISE && rise) ||
                                   (edgeLevelSelect == `TMC_EDGE_FALL && fall) ||
                                   (edgeLevelSelect == `TMC_EDGE_BOTH && (rise || fall)));
  wire        dutyEdge = (chanValue == 16'h0000) || (chanValue > top);
  wire        match    = running && !isCap && (count == chanValue) && !(isPwm && dutyEdge);
  // PWM edges act on the step that brings the counter onto the value, so the pin moves with the count.
  wire        pwmClr   = running && (next_count == chanValue) && !(centreAlignedSelect && next_countDown);
  wire        pwmSet   = running && centreAlignedSelect && next_countDown && (next_count == chanValue);
  wire        chanEvt  = capEvt || match;
  wire        lowTrue  = edgeLevelSelect[0];

  // APB slave: one wait state per access, unmapped addresses included; unmapped reads return zero.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= 1'b0;
      if (rdEn)
      begin
        case (paddr)
          `TMC_ADDR_STATUS_CTRL:   prdata <= {24'h00_0000, overflowFlag, overflowIe, centreAlignedSelect,
                                              clockSourceSelect, 3'b000};
          `TMC_ADDR_COUNT:         prdata <= {16'h0000, count};
          `TMC_ADDR_MOD_HIGH:      prdata <= {24'h00_0000, modulo[15:8]};
          `TMC_ADDR_MOD_LOW:       prdata <= {24'h00_0000, modulo[7:0]};
          `TMC_ADDR_CHAN_CTRL:     prdata <= {24'h00_0000, channelEventFlag, channelIrqEnable, channelMode,
                                              edgeLevelSelect, 2'b00};
          `TMC_ADDR_CHAN_VAL_HIGH: prdata <= {24'h00_0000, chanValue[15:8]};
          `TMC_ADDR_CHAN_VAL_LOW:  prdata <= {24'h00_0000, chanValue[7:0]};
          `TMC_ADDR_DEBUG:         prdata <= {31'h0000_0000, debugMode};
          default:                 prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Main control, counter and overflow flag.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clockSourceSelect   <= 2'b00;
      centreAlignedSelect <= 1'b0;
      overflowIe          <= 1'b0;
      overflowFlag        <= 1'b0;
      ovfArmed            <= 1'b0;
      xferWrap            <= 1'b0;
      count               <= 16'h0000;
      countDown           <= 1'b0;
      debugMode           <= 1'b0;
    end
    else
    begin
      if (wrDbg)
        debugMode <= pwdata[0];
      if (wrSc)
      begin
        clockSourceSelect   <= pwdata[`TMC_SC_CLK_HI:`TMC_SC_CLK_LO];
        centreAlignedSelect <= pwdata[`TMC_SC_CENTRE_BIT];
        overflowIe          <= pwdata[6];
      end
      if (rdSc && overflowFlag)
        ovfArmed <= 1'b1;
      if (wrCnt)
      begin
        count     <= 16'h0000;
        countDown <= 1'b0;
        xferWrap  <= 1'b0;
      end
      else if (running)
      begin
        count     <= next_count;
        countDown <= next_countDown;
        xferWrap  <= modXfer;
      end
      // An overflow in the same cycle as a clear write keeps the flag set.
      if (wrapEvt && !modHighSeen && !modLowSeen)
      begin
        overflowFlag <= 1'b1;
        ovfArmed     <= 1'b0;
      end
      else if (wrSc && !pwdata[`TMC_SC_OVF_BIT] && ovfArmed)
      begin
        overflowFlag <= 1'b0;
        ovfArmed     <= 1'b0;
      end
    end
  end

  // Modulo register with its coherent write buffer.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modulo      <= `TMC_MOD_RESET;
      modBufHigh  <= 8'h00;
      modBufLow   <= 8'h00;
      modHighSeen <= 1'b0;
      modLowSeen  <= 1'b0;
      modPending  <= 1'b0;
    end
    else if (wrSc)
    begin
      modHighSeen <= 1'b0;
      modLowSeen  <= 1'b0;
    end
    else if (debugMode)
    begin
      if (wrModH)
        modulo[15:8] <= pwdata[7:0];
      if (wrModL)
        modulo[7:0] <= pwdata[7:0];
    end
    else
    begin
      if (wrModH)
        modBufHigh <= pwdata[7:0];
      if (wrModL)
        modBufLow <= pwdata[7:0];
      if ((wrModH && modLowSeen) || (wrModL && modHighSeen))
      begin
        modHighSeen <= 1'b0;
        modLowSeen  <= 1'b0;
        if (clockSourceSelect == `TMC_CLK_OFF)
          modulo <= wrModH ? {pwdata[7:0], modBufLow} : {modBufHigh, pwdata[7:0]};
        else
          modPending <= 1'b1;
      end
      else
      begin
        if (wrModH)
          modHighSeen <= 1'b1;
        if (wrModL)
          modLowSeen <= 1'b1;
        if (modXfer)
        begin
          modulo     <= {modBufHigh, modBufLow};
          modPending <= 1'b0;
        end
      end
    end
  end

  // Channel control, flag, value and pin logic.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      channelEventFlag <= 1'b0;
      channelIrqEnable <= 1'b0;
      channelMode      <= 2'b00;
      edgeLevelSelect  <= 2'b00;
      chanArmed        <= 1'b0;
      chanValue        <= 16'h0000;
      pinMeta          <= 1'b0;
      pinSync          <= 1'b0;
      pinPrev          <= 1'b0;
      pinLevel         <= 1'b0;
      chanPinOut       <= 1'b0;
      chanPinOe        <= 1'b0;
      chanIrq          <= 1'b0;
    end
    else
    begin
      pinMeta <= chanPinIn;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
      if (wrCh)
      begin
        channelIrqEnable <= pwdata[`TMC_CH_IE_BIT];
        channelMode      <= pwdata[`TMC_CH_MODE_HI:`TMC_CH_MODE_LO];
        edgeLevelSelect  <= pwdata[`TMC_CH_EDGE_HI:`TMC_CH_EDGE_LO];
      end
      // A read while the flag is set arms the clear; a new event disarms it.
      if (rdCh && channelEventFlag)
        chanArmed <= 1'b1;
      if (chanEvt)
      begin
        channelEventFlag <= 1'b1;
        chanArmed        <= 1'b0;
      end
      else if (wrCh && !pwdata[`TMC_CH_FLAG_BIT] && chanArmed)
      begin
        channelEventFlag <= 1'b0;
        chanArmed        <= 1'b0;
      end
      if (capEvt)
        chanValue <= count;
      else if (!isCap && wrValH)
        chanValue[15:8] <= pwdata[7:0];
      else if (!isCap && wrValL)
        chanValue[7:0] <= pwdata[7:0];
      if (isPwm)
      begin
        if (centreAlignedSelect ? (count == 16'h0000) : wrapEvt)
          pinLevel <= !lowTrue;
        if (pwmSet)
          pinLevel <= !lowTrue;
        if (pwmClr)
          pinLevel <= lowTrue;
        // A zero value means 0% duty, so the pin stays at its inactive level.
        if (chanValue == 16'h0000)
          pinLevel <= lowTrue;
      end
      else if (match)
      begin
        case (edgeLevelSelect)
          `TMC_EDGE_RISE: pinLevel <= !pinLevel;
          `TMC_EDGE_FALL: pinLevel <= 1'b0;
          `TMC_EDGE_BOTH: pinLevel <= 1'b1;
          default:        pinLevel <= pinLevel;
        endcase
      end
      chanPinOut <= pinLevel;
      chanPinOe  <= edgeOn && !isCap;
      chanIrq    <= (channelEventFlag || chanEvt) && channelIrqEnable;
    end
  end

endmodule // tmc_timer

// ===== sim/tmc_props.sv
// Port checker for the timer: APB timing, pin release and interrupt gating.
// Assumes it is bound to every tmc_timer instance and sees only its ports.
`timescale 1ns/1ps
`include "tmc_defines.vh"
module tmc_props
(
  // Clock and reset.
  input wire        mclk,
  input wire        rst_b,
  // APB.
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Channel pin and interrupt.
  input wire        chanPinIn,
  input wire        chanPinOut,
  input wire        chanPinOe,
  input wire        chanIrq
);
  reg  [7:0] ch;
  reg        cp;
  wire       relQ = ch[3:2] == 2'b00;
  wire       capQ = ch[5:4] == 2'b00 && !cp;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Shadows of the channel and centre-aligned settings, taken when a write lands.
  always @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      ch <= 8'h00;
      cp <= 1'b0;
    end
    else if (psel && penable && pwrite && pready)
    begin
      if (paddr == `TMC_ADDR_CHAN_CTRL)
        ch <= pwdata[7:0];
      if (paddr == `TMC_ADDR_STATUS_CTRL)
        cp <= pwdata[`TMC_SC_CENTRE_BIT];
    end
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_no_err: assert property (pslverr == 1'b0)
    else $error("pslverr raised");
  a_unmapped_zero: assert property (pready && !pwrite && paddr > 8'h1C |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_pin_release: assert property (relQ && $past(relQ) && $past(relQ, 2) |-> !chanPinOe)
    else $error("pin driven with edge field zero");
  a_capture_quiet: assert property (capQ && $past(capQ) && $past(capQ, 2) |-> !chanPinOe)
    else $error("pin driven in capture mode");
  a_irq_enable: assert property (!ch[6] && !$past(ch[6]) && !$past(ch[6], 2) |-> !chanIrq)
    else $error("interrupt with enable clear");
  a_reset_quiet: assert property ($rose(rst_b) |-> !chanIrq && !chanPinOe)
    else $error("outputs active after reset");
  c_write: cover property (pready && pwrite);
  c_irq: cover property (chanIrq);
  c_pin: cover property ($rose(chanPinOut));
endmodule // tmc_props
bind tmc_timer tmc_props i_props (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chanPinIn(chanPinIn), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .chanIrq(chanIrq));

// ===== sim/tmc_pin_model.sv
// External source on the channel pin.
// Assumes the bench sets extLevel; the timer wins the wire while it drives.
`timescale 1ns/1ps
module tmc_pin_model
(
  // Timer side.
  input  wire chanPinOut,
  input  wire chanPinOe,
  // Source level and resolved wire.
  input  wire extLevel,
  output wire pinWire
);
  assign pinWire = chanPinOe ? chanPinOut : extLevel;
endmodule // tmc_pin_model

// ===== sim/tmc_timer_bench.sv
// Self-checking bench for the timer against a modulo register model.
// Assumes the APB map of tmc_defines.vh and one wait state per access.
`timescale 1ns/1ps
`include "tmc_defines.vh"
module tmc_timer_bench;
  reg         mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, extLevel = 0;
  reg  [7:0]  paddr = 8'h00, q;
  reg  [31:0] pwdata = 32'h0000_0000, r;
  reg  [15:0] modv = 16'h0000, bufv = 16'h0000;
  wire [31:0] prdata;
  wire        pready, pslverr, chanPinOut, chanPinOe, chanIrq, pinWire;
  integer     n_errors = 0, cmp_count = 0, pend = 0, dbg = 0, e, i, hc;
  always #5 mclk = ~mclk;
  tmc_timer i_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chanPinIn(pinWire), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .chanIrq(chanIrq));
  tmc_pin_model i_pin (.chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .extLevel(extLevel), .pinWire(pinWire));
  task test_done;
    begin
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] ex, input [15:0] got);
    begin
      cmp_count++;
      if (got !== ex)
      begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [7:0] d);
    integer n;
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge mclk) penable <= 1;
      n = 0;
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 1, pready);
      q = prdata[7:0];
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
    end
  endtask
  task rdc(input [7:0] a, input [7:0] ex, input string nm);
    begin
      apb(0, a, 8'h00);
      chk(nm, ex, q);
    end
  endtask
  task rdm;
    begin
      rdc(`TMC_ADDR_MOD_HIGH, modv[15:8], "mod_high");
      rdc(`TMC_ADDR_MOD_LOW, modv[7:0], "mod_low");
    end
  endtask
  task mw(input h, input [7:0] d);
    begin
      apb(1, h ? `TMC_ADDR_MOD_HIGH : `TMC_ADDR_MOD_LOW, d);
      if (dbg)
        modv = h ? {d, modv[7:0]} : {modv[15:8], d};
      else
      begin
        bufv = h ? {d, bufv[7:0]} : {bufv[15:8], d};
        pend = pend | (h ? 1 : 2);
        if (pend == 3)
        begin
          modv = bufv;
          pend = 0;
        end
      end
    end
  endtask
  task wsc(input [7:0] d);
    begin
      apb(1, `TMC_ADDR_STATUS_CTRL, d);
      pend = 0;
    end
  endtask
  initial
  begin
    #100000;
    n_errors++;
    test_done;
  end
  initial
  begin
    r = $urandom(12);
    repeat (3) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    rdm;
    rdc(`TMC_ADDR_CHAN_CTRL, 8'h00, "chan_ctrl");
    rdc(8'h20, 8'h00, "unmapped");
    r = $urandom;
    mw(1, r[7:0]);
    rdm;
    mw(0, r[15:8]);
    rdm;
    mw(1, r[23:16]);
    wsc(8'h00);
    mw(0, 8'h14);
    rdm;
    apb(1, `TMC_ADDR_DEBUG, 8'h01);
    dbg = 1;
    mw(1, r[31:24]);
    rdm;
    apb(1, `TMC_ADDR_DEBUG, 8'h00);
    dbg = 0;
    mw(1, 8'h00);
    rdm;
    apb(1, `TMC_ADDR_COUNT, 8'h00);
    wsc(8'h08);
    repeat (30) @(posedge mclk);
    apb(0, `TMC_ADDR_STATUS_CTRL, 8'h00);
    chk("ovf", 1, q[7]);
    apb(1, `TMC_ADDR_COUNT, 8'h00);
    wsc(8'h08);
    mw(1, 8'h00);
    repeat (50) @(posedge mclk);
    apb(0, `TMC_ADDR_STATUS_CTRL, 8'h00);
    chk("ovf_held", 0, q[7]);
    mw(0, 8'h0A);
    repeat (40) @(posedge mclk);
    rdm;
    apb(0, `TMC_ADDR_COUNT, 8'h00);
    chk("count_le_mod", 1, q <= modv);
    apb(1, `TMC_ADDR_CHAN_VAL_LOW, 8'h05);
    for (e = 1; e < 4; e++)
    begin
      apb(1, `TMC_ADDR_CHAN_CTRL, 8'(8'h50 | e << 2));
      repeat (25) @(posedge mclk);
      apb(0, `TMC_ADDR_CHAN_CTRL, 8'h00);
      chk("chan_flag", 1, q[7]);
      chk("irq", 1, chanIrq);
      hc = chanPinOut;
      repeat (11) @(posedge mclk);
      chk("pin", e == 1 ? !hc : e == 3, chanPinOut);
    end
    apb(1, `TMC_ADDR_CHAN_CTRL, 8'h00);
    for (e = 0; e < 4; e++)
    begin
      repeat (3) @(posedge mclk);
      apb(0, `TMC_ADDR_CHAN_CTRL, 8'h00);
      apb(1, `TMC_ADDR_CHAN_CTRL, 8'(e << 2));
      apb(1, `TMC_ADDR_CHAN_CTRL, 8'(8'h80 | e << 2));
      rdc(`TMC_ADDR_CHAN_CTRL, 8'(e << 2), "flag_clear");
      extLevel <= 1;
      repeat (6) @(posedge mclk);
      rdc(`TMC_ADDR_CHAN_CTRL, 8'(e << 2 | (e & 1) << 7), "cap_rise");
      apb(0, `TMC_ADDR_CHAN_CTRL, 8'h00);
      apb(1, `TMC_ADDR_CHAN_CTRL, 8'(e << 2));
      extLevel <= 0;
      repeat (6) @(posedge mclk);
      rdc(`TMC_ADDR_CHAN_CTRL, 8'(e << 2 | (e >> 1) << 7), "cap_fall");
    end
    apb(0, `TMC_ADDR_CHAN_CTRL, 8'h00);
    extLevel <= 1;
    repeat (6) @(posedge mclk);
    apb(1, `TMC_ADDR_CHAN_CTRL, 8'h0C);
    rdc(`TMC_ADDR_CHAN_CTRL, 8'h8C, "restart");
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
        wsc(8'h28);
      apb(1, `TMC_ADDR_CHAN_CTRL, i == 1 ? 8'h24 : 8'h28);
      apb(1, `TMC_ADDR_CHAN_VAL_HIGH, 8'h00);
      apb(1, `TMC_ADDR_CHAN_VAL_LOW, 8'h04);
      repeat (30) @(posedge mclk);
      hc = 0;
      repeat (i == 2 ? 20 : 11)
      begin
        @(posedge mclk);
        hc += chanPinOut === (i != 1);
      end
      chk("pwm_duty", i == 2 ? 8 : 4, hc);
    end
    wsc(8'h08);
    apb(1, `TMC_ADDR_CHAN_VAL_LOW, 8'h00);
    apb(0, `TMC_ADDR_CHAN_CTRL, 8'h00);
    apb(1, `TMC_ADDR_CHAN_CTRL, 8'h28);
    repeat (30) @(posedge mclk);
    rdc(`TMC_ADDR_CHAN_CTRL, 8'h28, "pwm_zero");
    wsc(8'h00);
    apb(0, `TMC_ADDR_COUNT, 8'h00);
    hc = q;
    repeat (10) @(posedge mclk);
    rdc(`TMC_ADDR_COUNT, 8'(hc), "count_held");
    test_done;
  end
endmodule // tmc_timer_bench
